// ==== core/schc_top.sv ====
// Smart card host control: pin latch, sequencer, clock and line relay.
`timescale 1ns/1ps
`default_nettype none
module schc_top (
  // Clock, reset and enable
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Host control pins
  input  wire logic chip_select_i,
  input  wire logic activation_command_n_i,
  input  wire logic host_card_reset_in_i,
  input  wire logic power_down_request_i,
  input  wire logic card_voltage_select_i,
  input  wire logic divider_select_high_i,
  input  wire logic divider_select_low_i,
  input  wire logic card_clock_mode_select_i,
  input  wire logic strobe_i,
  input  wire logic oscillator_input_i,
  // Card status and protection inputs
  input  wire logic card_present_i,
  input  wire logic vcc_fault_i,
  input  wire logic over_temp_i,
  input  wire logic over_current_i,
  // Host side lines
  input  wire logic host_card_data_line_i,
  output logic      host_card_data_line_o,
  output logic      host_card_data_line_oe_o,
  input  wire logic host_aux_line_a_i,
  output logic      host_aux_line_a_o,
  output logic      host_aux_line_a_oe_o,
  input  wire logic host_aux_line_b_i,
  output logic      host_aux_line_b_o,
  output logic      host_aux_line_b_oe_o,
  // Card side lines (data, C4, C8)
  input  wire logic card_data_i,
  output logic      card_data_o,
  output logic      card_data_oe_o,
  input  wire logic card_c4_i,
  output logic      card_c4_o,
  output logic      card_c4_oe_o,
  input  wire logic card_c8_i,
  output logic      card_c8_o,
  output logic      card_c8_oe_o,
  // Card supply, clock and reset
  output logic      card_clk_o,
  output logic      card_rst_o,
  output logic      card_vcc_enable_o,
  output logic      card_voltage_high_o,
  // Interrupt and oscillator buffer
  output logic      fault_irq_n_o,
  output logic      fault_irq_n_oe_o,
  output logic      oscillator_buffer_out_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [19:0] pin_raw;
  logic [19:0] s1_r;
  logic [19:0] s2_r;
  logic [19:0] s3_r;
  logic [19:0] pin_r;

  assign pin_raw = {card_c8_i, card_c4_i, card_data_i,
                    host_aux_line_b_i, host_aux_line_a_i,
                    host_card_data_line_i, oscillator_input_i,
                    over_current_i, over_temp_i, vcc_fault_i,
                    card_present_i, strobe_i, card_clock_mode_select_i,
                    divider_select_low_i, divider_select_high_i,
                    card_voltage_select_i, power_down_request_i,
                    host_card_reset_in_i, activation_command_n_i,
                    chip_select_i};

  // Each pin passes three stages; a change is accepted only once the
  // second and third agree, which rejects single-sample glitches.
  genvar gp;
  generate
    for (gp = 0; gp < schc_pkg::NPIN; gp++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          s1_r[gp]  <= schc_pkg::PIN_RST[gp];
          s2_r[gp]  <= schc_pkg::PIN_RST[gp];
          s3_r[gp]  <= schc_pkg::PIN_RST[gp];
          pin_r[gp] <= schc_pkg::PIN_RST[gp];
        end else if (ce_i) begin
          s1_r[gp] <= pin_raw[gp];
          s2_r[gp] <= s1_r[gp];
          s3_r[gp] <= s2_r[gp];
          if (s2_r[gp] == s3_r[gp]) begin
            pin_r[gp] <= s3_r[gp];
          end
        end
      end
    end
  endgenerate

  logic cs;
  logic present;
  logic fault_any;
  logic osc;
  assign cs        = pin_r[schc_pkg::P_CS];
  assign present   = pin_r[schc_pkg::P_PRES];
  assign osc       = pin_r[schc_pkg::P_OSC];
  assign fault_any = pin_r[schc_pkg::P_VFAULT] | pin_r[schc_pkg::P_OTEMP]
                   | pin_r[schc_pkg::P_OCURR] | ~present;

  // ----------------------------------------------------------------
  // Control latch
  // ----------------------------------------------------------------
  schc_pkg::schc_ctrl_type live;
  schc_pkg::schc_ctrl_type held_r;
  schc_pkg::schc_ctrl_type held_prev_r;

  assign live = '{act_n:  pin_r[schc_pkg::P_ACT_N],
                  rst_in: pin_r[schc_pkg::P_HOST_CARD_RESET_IN],
                  power_down_request:  pin_r[schc_pkg::P_POWER_DOWN_REQUEST],
                  vsel:   pin_r[schc_pkg::P_VSEL],
                  div_hi: pin_r[schc_pkg::P_DIVHI],
                  div_lo: pin_r[schc_pkg::P_DIVLO],
                  mode:   pin_r[schc_pkg::P_MODE]};

  // Held copy tracks the pins while selected and freezes otherwise;
  // the previous copy turns a falling step of act_n into an edge command.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      held_r      <= schc_pkg::CTRL_RST;
      held_prev_r <= schc_pkg::CTRL_RST;
    end else if (ce_i) begin
      held_prev_r <= held_r;
      if (cs) begin
        held_r <= live;
      end
    end
  end

  // ----------------------------------------------------------------
  // Activation sequencer
  // ----------------------------------------------------------------
  schc_pkg::schc_state_type state_r;
  logic [3:0] step_r;
  logic       fault_r;
  logic       act_fall;

  assign act_fall = held_prev_r.act_n & ~held_r.act_n;

  // Power-down blocks activation; the host must not raise it inside a
  // session, so it is not watched while active.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= schc_pkg::S_IDLE;
      step_r  <= 4'h0;
      fault_r <= 1'b0;
    end else if (ce_i) begin
      case (state_r)
        schc_pkg::S_IDLE: begin
          step_r <= 4'h0;
          if (held_r.act_n) begin
            fault_r <= 1'b0;
          end
          if (act_fall && present && !held_r.power_down_request) begin
            state_r <= schc_pkg::S_POWERUP;
            fault_r <= 1'b0;
          end
        end
        schc_pkg::S_POWERUP, schc_pkg::S_ACTIVE: begin
          if (fault_any) begin
            fault_r <= 1'b1;
            state_r <= schc_pkg::S_DEACT;
            step_r  <= 4'h0;
          end else if (held_r.act_n) begin
            state_r <= schc_pkg::S_DEACT;
            step_r  <= 4'h0;
          end else if (state_r == schc_pkg::S_POWERUP) begin
            if (step_r == schc_pkg::SEQ_STEP_LAST) begin
              state_r <= schc_pkg::S_ACTIVE;
            end else begin
              step_r <= step_r + 4'h1;
            end
          end
        end
        schc_pkg::S_DEACT: begin
          if (fault_any) begin
            fault_r <= 1'b1;
          end
          if (step_r == schc_pkg::SEQ_STEP_LAST) begin
            state_r <= schc_pkg::S_IDLE;
          end else begin
            step_r <= step_r + 4'h1;
          end
        end
        default: begin
          state_r <= schc_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Card clock divider
  // ----------------------------------------------------------------
  logic       osc_prev_r;
  logic [2:0] div_cnt_r;
  logic [1:0] div_sel;
  logic       div_clk;

  assign div_sel = {held_r.div_hi, held_r.div_lo};

  // Counter bits toggle on oscillator rising edges only, so every
  // divided output is high for exactly half its period.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_prev_r <= 1'b0;
      div_cnt_r  <= 3'h0;
    end else if (ce_i) begin
      osc_prev_r <= osc;
      if (osc && !osc_prev_r) begin
        div_cnt_r <= div_cnt_r + 3'h1;
      end
    end
  end

  always_comb begin
    case (div_sel)
      schc_pkg::DIV_EIGHTH:  div_clk = div_cnt_r[2];
      schc_pkg::DIV_QUARTER: div_clk = div_cnt_r[1];
      schc_pkg::DIV_HALF:    div_clk = div_cnt_r[0];
      default:               div_clk = osc;
    endcase
  end

  // ----------------------------------------------------------------
  // Card clock, reset, supply and oscillator buffer
  // ----------------------------------------------------------------
  logic active;
  assign active = (state_r == schc_pkg::S_ACTIVE);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      card_clk_o              <= 1'b0;
      card_rst_o              <= 1'b0;
      card_vcc_enable_o       <= 1'b0;
      card_voltage_high_o     <= 1'b0;
      oscillator_buffer_out_o <= 1'b0;
    end else if (ce_i) begin
      oscillator_buffer_out_o <= osc;
      card_voltage_high_o     <= held_r.vsel;
      card_vcc_enable_o       <= (state_r != schc_pkg::S_IDLE);
      if (held_r.mode) begin
        card_clk_o <= pin_r[schc_pkg::P_STROBE];
        card_rst_o <= held_r.rst_in;
      end else begin
        card_clk_o <= active & div_clk;
        card_rst_o <= active & held_r.rst_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line relay and interrupt
  // ----------------------------------------------------------------
  logic [2:0] host_in;
  logic [2:0] card_in;
  logic [2:0] host_oe_r;
  logic [2:0] card_oe_r;
  logic [2:0] host_o_r;
  logic [2:0] card_o_r;
  logic [2:0][3:0] host_hist_r;
  logic [2:0][3:0] card_hist_r;

  assign host_in = pin_r[schc_pkg::P_HOST0 +: schc_pkg::NLINE];
  assign card_in = pin_r[schc_pkg::P_CARD0 +: schc_pkg::NLINE];

  // A side pulled low by us is not copied back, so a driven line can
  // never latch itself low through the relay loop. The lockout lasts
  // four more clocks after release, since the filtered input lags the
  // pin by that much and would otherwise echo our own drive back.
  genvar gl;
  generate
    for (gl = 0; gl < schc_pkg::NLINE; gl++) begin : g_line
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          host_oe_r[gl] <= 1'b0;
          card_oe_r[gl] <= 1'b0;
          host_o_r[gl]  <= 1'b0;
          card_o_r[gl]  <= 1'b0;
          host_hist_r[gl] <= 4'h0;
          card_hist_r[gl] <= 4'h0;
        end else if (ce_i) begin
          host_o_r[gl]  <= 1'b0;
          card_o_r[gl]  <= 1'b0;
          host_hist_r[gl] <= {host_hist_r[gl][2:0], host_oe_r[gl]};
          card_hist_r[gl] <= {card_hist_r[gl][2:0], card_oe_r[gl]};
          host_oe_r[gl] <= cs & ~card_in[gl] & ~card_oe_r[gl]
                           & ~(|card_hist_r[gl]);
          card_oe_r[gl] <= cs & ~host_in[gl] & ~host_oe_r[gl]
                           & ~(|host_hist_r[gl]);
        end
      end
    end
  endgenerate

  assign host_card_data_line_o    = host_o_r[0];
  assign host_card_data_line_oe_o = host_oe_r[0];
  assign host_aux_line_a_o        = host_o_r[1];
  assign host_aux_line_a_oe_o     = host_oe_r[1];
  assign host_aux_line_b_o        = host_o_r[2];
  assign host_aux_line_b_oe_o     = host_oe_r[2];
  assign card_data_o              = card_o_r[0];
  assign card_data_oe_o           = card_oe_r[0];
  assign card_c4_o                = card_o_r[1];
  assign card_c4_oe_o             = card_oe_r[1];
  assign card_c8_o                = card_o_r[2];
  assign card_c8_oe_o             = card_oe_r[2];

  // Open-drain interrupt: the pin only ever sinks, the pull-up lifts it.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_irq_n_o    <= 1'b0;
      fault_irq_n_oe_o <= 1'b0;
    end else if (ce_i) begin
      fault_irq_n_o    <= 1'b0;
      fault_irq_n_oe_o <= cs & (fault_r | (state_r == schc_pkg::S_IDLE
                          & held_r.act_n & ~present));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_held_frozen: assert property (ce_i && !cs |=> $stable(held_r))
    else $error("held controls changed while deselected");
  a_held_tracks: assert property (ce_i && cs |=> held_r == $past(live))
    else $error("held controls did not follow live pins");
  a_lines_released: assert property (ce_i && !cs |=> host_oe_r == 3'h0)
    else $error("host line driven while deselected");
  a_irq_tristate: assert property (ce_i && !cs |=> !fault_irq_n_oe_o)
    else $error("interrupt driven while deselected");
  a_sync_clock: assert property (ce_i && held_r.mode
    |=> card_clk_o == $past(pin_r[schc_pkg::P_STROBE]))
    else $error("sync card clock not strobe copy");
  a_async_quiet: assert property (ce_i && !held_r.mode && !active
    |=> !card_clk_o && !card_rst_o)
    else $error("card clock or reset moved outside activation");
  a_act_needs_card: assert property (ce_i && state_r == schc_pkg::S_IDLE
    && !present |=> state_r == schc_pkg::S_IDLE)
    else $error("activation without card");
  a_reset_follow: assert property (ce_i && active
    |=> card_rst_o == $past(held_r.rst_in))
    else $error("card reset not following host reset");
  a_fault_deact: assert property (ce_i && active && fault_any
    |=> state_r == schc_pkg::S_DEACT ##0 fault_r
    ##1 (!ce_i || !cs || fault_irq_n_oe_o))
    else $error("fault did not deactivate and flag");
  a_no_card_irq: assert property (ce_i && cs && !fault_r && held_r.act_n
    && state_r == schc_pkg::S_IDLE && !present |=> fault_irq_n_oe_o)
    else $error("missing card not reported");
  a_undivided: assert property (ce_i && active && !held_r.mode
    && div_sel == schc_pkg::DIV_NONE |=> card_clk_o == $past(osc))
    else $error("undivided clock not passed through");
  a_osc_buffer: assert property (ce_i
    |=> oscillator_buffer_out_o == $past(osc))
    else $error("oscillator buffer mismatch");
  a_voltage_sel: assert property (ce_i
    |=> card_voltage_high_o == $past(held_r.vsel))
    else $error("card voltage select mismatch");

  c_activation: cover property (state_r == schc_pkg::S_POWERUP
    ##[1:40] state_r == schc_pkg::S_ACTIVE);
  c_fault_exit: cover property (active && fault_any
    ##1 state_r == schc_pkg::S_DEACT);
  c_deselect_hold: cover property (cs ##1 !cs [*4] ##1 cs);
  c_sync_mode: cover property (held_r.mode && card_clk_o);

endmodule
`default_nettype wire

// ==== core/schc_pkg.sv ====
// Shared constants and types of the smart card host control block.
`default_nettype none
package schc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  // Dwell of the whole power-up phase and of the whole deactivation phase, in ns.
  localparam int unsigned SEQ_STEP_NS    = 800;
  localparam int unsigned SEQ_STEP_CYC   =
    (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SEQ_STEP_LAST  = 4'(SEQ_STEP_CYC - 1);

  // ----------------------------------------------------------------
  // Pin synchroniser layout
  // ----------------------------------------------------------------
  localparam int unsigned NPIN      = 20;
  localparam int unsigned P_CS      = 0;
  localparam int unsigned P_ACT_N   = 1;
  localparam int unsigned P_HOST_CARD_RESET_IN   = 2;
  localparam int unsigned P_POWER_DOWN_REQUEST   = 3;
  localparam int unsigned P_VSEL    = 4;
  localparam int unsigned P_DIVHI   = 5;
  localparam int unsigned P_DIVLO   = 6;
  localparam int unsigned P_MODE    = 7;
  localparam int unsigned P_STROBE  = 8;
  localparam int unsigned P_PRES    = 9;
  localparam int unsigned P_VFAULT  = 10;
  localparam int unsigned P_OTEMP   = 11;
  localparam int unsigned P_OCURR   = 12;
  localparam int unsigned P_OSC     = 13;
  localparam int unsigned P_HOST0   = 14;
  localparam int unsigned P_CARD0   = 17;
  localparam int unsigned NLINE     = 3;
  // Filtered line pins and act_n settle high, as the lines carry pull-ups.
  localparam logic [19:0] PIN_RST   = 20'hFC002;

  // ----------------------------------------------------------------
  // Clock divider codes {high,low}
  // ----------------------------------------------------------------
  localparam logic [1:0] DIV_EIGHTH  = 2'h0;
  localparam logic [1:0] DIV_NONE    = 2'h1;
  localparam logic [1:0] DIV_QUARTER = 2'h2;
  localparam logic [1:0] DIV_HALF    = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic act_n;
    logic rst_in;
    logic power_down_request;
    logic vsel;
    logic div_hi;
    logic div_lo;
    logic mode;
  } schc_ctrl_type;

  localparam schc_ctrl_type CTRL_RST = 7'h40;

  typedef enum logic [1:0] {
    S_IDLE,
    S_POWERUP,
    S_ACTIVE,
    S_DEACT
  } schc_state_type;

endpackage
`default_nettype wire

// ==== sim/schc_card_model.sv ====
// Card side model: contact pull-ups, card line drivers and presence switch.
`timescale 1ns/1ps
`default_nettype none
module schc_card_model (
  // Bench controls
  input  wire logic       present_i,
  input  wire logic [2:0] pull_low_i,
  // Device drivers on data, C4 and C8
  input  wire logic [2:0] dev_oe_i,
  // Resolved contacts and presence
  output logic      [2:0] line_o,
  output logic            card_present_o
);
  // A withdrawn card drives nothing, so only the pull-ups and the device drivers remain.
  assign line_o = ~((pull_low_i & {3{present_i}}) | dev_oe_i);
  // The presence switch follows the card in the reader.
  assign card_present_o = present_i;
endmodule
`default_nettype wire

// ==== sim/schc_tb_top.sv ====
// Self-checking bench for the smart card host control block.
`timescale 1ns/1ps
`default_nettype none
module schc_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk, rst_n, cs, act_n, host_card_reset_in, power_down_request, vsel, dhi, dlo;
  logic       mode, strobe, osc, present, vf, ot, oc, pres_lvl;
  logic [2:0] host_pull, card_pull, host_oe, card_oe, card_lvl;
  logic [2:0] osc_cnt, stb_cnt;
  logic       card_clk, card_rst, vcc_en, vhigh, irq_oe, osc_buf;
  logic       irq_drv;
  logic [5:0] line_drv;
  int         err_total, num_checks, hi, lo, k;
  wire  [2:0] host_lvl = ~(host_pull | host_oe);
  wire        irq_n    = ~irq_oe;

  // ----------------------------------------------------------------
  // Clock, oscillator and strobe
  // ----------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  // Oscillator half period 8 clocks, strobe 5, both above the filter.
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 3'h1;
    if (osc_cnt == 3'h7) osc <= ~osc;
    stb_cnt <= (stb_cnt == 3'h4) ? 3'h0 : stb_cnt + 3'h1;
    if (stb_cnt == 3'h4) strobe <= ~strobe;
  end

  // ----------------------------------------------------------------
  // Design and card model
  // ----------------------------------------------------------------
  schc_top schc_top_i (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .chip_select_i(cs),
    .activation_command_n_i(act_n), .host_card_reset_in_i(host_card_reset_in),
    .power_down_request_i(power_down_request), .card_voltage_select_i(vsel),
    .divider_select_high_i(dhi), .divider_select_low_i(dlo),
    .card_clock_mode_select_i(mode), .strobe_i(strobe),
    .oscillator_input_i(osc), .card_present_i(pres_lvl),
    .vcc_fault_i(vf), .over_temp_i(ot), .over_current_i(oc),
    .host_card_data_line_i(host_lvl[0]),
    .host_card_data_line_o(line_drv[0]),
    .host_card_data_line_oe_o(host_oe[0]),
    .host_aux_line_a_i(host_lvl[1]), .host_aux_line_a_o(line_drv[1]),
    .host_aux_line_a_oe_o(host_oe[1]),
    .host_aux_line_b_i(host_lvl[2]), .host_aux_line_b_o(line_drv[2]),
    .host_aux_line_b_oe_o(host_oe[2]),
    .card_data_i(card_lvl[0]), .card_data_o(line_drv[3]),
    .card_data_oe_o(card_oe[0]),
    .card_c4_i(card_lvl[1]), .card_c4_o(line_drv[4]),
    .card_c4_oe_o(card_oe[1]),
    .card_c8_i(card_lvl[2]), .card_c8_o(line_drv[5]),
    .card_c8_oe_o(card_oe[2]),
    .card_clk_o(card_clk), .card_rst_o(card_rst),
    .card_vcc_enable_o(vcc_en), .card_voltage_high_o(vhigh),
    .fault_irq_n_o(irq_drv), .fault_irq_n_oe_o(irq_oe),
    .oscillator_buffer_out_o(osc_buf)
  );
  schc_card_model schc_card_model_i (
    .present_i(present), .pull_low_i(card_pull), .dev_oe_i(card_oe),
    .line_o(card_lvl), .card_present_o(pres_lvl)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  // Inputs change by non-blocking assignment right after these edges.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic probe(input bit s);
    return s ? osc_buf : card_clk;
  endfunction
  // Counts cycles while the probed output holds level v, bounded.
  task automatic run_lvl(input bit s, input logic v, output int n);
    n = 0;
    while (probe(s) === v && n < 300) begin
      cyc(1);
      n++;
    end
    if (n >= 300) begin
      err_total++;
      wrap_up();
    end
  endtask
  // High and low times of one whole period, from a rising edge.
  task automatic measure(input bit s);
    run_lvl(s, 1'b1, hi);
    run_lvl(s, 1'b0, hi);
    run_lvl(s, 1'b1, hi);
    run_lvl(s, 1'b0, lo);
  endtask
  // A fresh falling step of the activation command.
  task automatic activate();
    act_n <= 1'b1;
    cyc(12);
    act_n <= 1'b0;
    cyc(25);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rst_n = 0; cs = 1; act_n = 1; host_card_reset_in = 0; power_down_request = 0;
    vsel = 0; dhi = 0; dlo = 0; mode = 0; strobe = 0; osc = 0;
    present = 1; vf = 0; ot = 0; oc = 0; host_pull = 3'h0;
    card_pull = 3'h0; osc_cnt = 3'h0; stb_cnt = 3'h0;
    err_total = 0; num_checks = 0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(12);
    check("vcc_idle", 8'(vcc_en), 8'h00);
    check("clk_idle", 8'(card_clk), 8'h00);
    check("irq_card", 8'(irq_n), 8'h01);
    // Presence reporting and release of the interrupt.
    present <= 1'b0;
    cyc(12);
    check("irq_nocard", 8'(irq_n), 8'h00);
    check("irq_sink", 8'(irq_drv), 8'h00);
    cs <= 1'b0;
    cyc(12);
    check("irq_cs_low", 8'(irq_oe), 8'h00);
    cs <= 1'b1;
    activate();
    check("vcc_nocard", 8'(vcc_en), 8'h00);
    // Power-down is raised only while no session is open.
    present <= 1'b1;
    power_down_request <= 1'b1;
    activate();
    check("vcc_power_down_request", 8'(vcc_en), 8'h00);
    power_down_request <= 1'b0;
    vsel <= 1'b1;
    activate();
    check("vcc_on", 8'(vcc_en), 8'h01);
    check("vhigh", 8'(vhigh), 8'h01);
    check("rst_low", 8'(card_rst), 8'h00);
    host_card_reset_in <= 1'b1;
    cyc(12);
    check("rst_high", 8'(card_rst), 8'h01);
    // Every divider code; the strobe keeps toggling throughout.
    for (k = 0; k < 4; k++) begin
      {dhi, dlo} <= 2'(k);
      cyc(60);
      measure(0);
      hi = (k == 1) ? hi + lo : hi;
      lo = (k == 1) ? 0 : lo;
      check("clk_hi", 8'(hi), (k == 1) ? 8'h10 : (k == 0) ? 8'h40
            : (k == 2) ? 8'h20 : 8'h10);
      check("clk_lo", 8'(lo), (k == 1) ? 8'h00 : (k == 0) ? 8'h40
            : (k == 2) ? 8'h20 : 8'h10);
    end
    measure(1);
    check("osc_buf", 8'(hi + lo), 8'h10);
    // Relay in both directions on all three lines.
    for (k = 0; k < 3; k++) begin
      host_pull <= 3'(1 << k);
      cyc(12);
      check("to_card", 8'(card_oe), 8'(1 << k));
      host_pull <= 3'h0;
      cyc(12);
      card_pull <= 3'(1 << k);
      cyc(12);
      check("to_host", 8'(host_oe), 8'(1 << k));
      check("line_sink", 8'(line_drv), 8'h00);
      card_pull <= 3'h0;
      cyc(12);
    end
    // Deselected: lines released, controls frozen.
    cs <= 1'b0;
    cyc(12);
    host_pull <= 3'h1;
    card_pull <= 3'h2;
    vsel <= 1'b0;
    act_n <= 1'b1;
    cyc(25);
    check("card_oe_off", 8'(card_oe), 8'h00);
    check("host_oe_off", 8'(host_oe), 8'h00);
    check("vhigh_held", 8'(vhigh), 8'h01);
    check("vcc_held", 8'(vcc_en), 8'h01);
    host_pull <= 3'h0;
    card_pull <= 3'h0;
    cs <= 1'b1;
    cyc(30);
    check("vcc_resume", 8'(vcc_en), 8'h00);
    // Synchronous mode: strobe clocks the card, reset follows host.
    mode <= 1'b1;
    activate();
    measure(0);
    check("sync_hi", 8'(hi), 8'h05);
    check("sync_lo", 8'(lo), 8'h05);
    host_card_reset_in <= 1'b0;
    cyc(12);
    check("sync_rst", 8'(card_rst), 8'h00);
    mode <= 1'b0;
    // Removal and each protection fault end the session.
    for (k = 0; k < 4; k++) begin
      activate();
      check("vcc_sess", 8'(vcc_en), 8'h01);
      present <= (k != 0);
      {vf, ot, oc} <= 3'(8 >> k);
      cyc(12);
      check("irq_fault", 8'(irq_n), 8'h00);
      cyc(20);
      check("vcc_deact", 8'(vcc_en), 8'h00);
      present <= 1'b1;
      {vf, ot, oc} <= 3'h0;
      act_n <= 1'b1;
      cyc(20);
      check("irq_clear", 8'(irq_n), 8'h01);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
